// >>> hw/hvoc_top.sv
// module: mode sequencing, code registers and output control of the hv dac core
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module hvoc_top
  import hvoc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              link_clk,
  input  wire logic              vio_ok,
  input  wire logic              link_wr,
  input  wire logic [IDX_W-1:0]  link_addr,
  input  wire logic [DATA_W-1:0] link_data,
  output logic                   link_busy,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [CODE_W-1:0]      high_voltage_output_a_code,
  output logic [CODE_W-1:0]      high_voltage_output_b_code,
  output logic [CODE_W-1:0]      high_voltage_output_c_code,
  output logic [LVL_W-1:0]       high_voltage_output_a_mv,
  output logic [LVL_W-1:0]       high_voltage_output_b_mv,
  output logic [LVL_W-1:0]       high_voltage_output_c_mv,
  output logic                   high_voltage_output_a_pulldown,
  output logic                   high_voltage_output_b_pulldown,
  output logic                   high_voltage_output_c_pulldown,
  output logic                   boost_en,
  output logic [1:0]             mode_state
);

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // index 0 is output c, 1 is b, 2 is a, matching the register numbers
  logic [CODE_W-1:0] code_r [NUM_OUT];
  logic [LVL_W-1:0]  lvl_r  [NUM_OUT];
  logic [NUM_OUT-1:0] pd_r;

  // code to millivolts, piecewise with three step sizes
  function automatic logic [LVL_W-1:0] code_to_mv(input logic [CODE_W-1:0] c);
    logic [LVL_W-1:0] cw;
    logic [LVL_W-1:0] res;
    cw = {8'h00, c};
    if (c <= CODE_BRK1)
      res = LVL_W'(cw * STEP1_MV);
    else if (c <= CODE_BRK2)
      res = LVL_W'(LVL_BRK1 + (cw - {8'h00, CODE_BRK1}) * STEP2_MV);
    else
      res = LVL_W'(LVL_BRK2 + (cw - {8'h00, CODE_BRK2}) * STEP3_MV);
    return res;
  endfunction

  // byte address to index; bit 0 flags a misaligned address or one outside the word window
  function automatic logic [IDX_W:0] addr_to_idx(input logic [AXI_AW-1:0] a);
    return {a[IDX_W+1:2], (a[1:0] != 2'h0) || a[AXI_AW-1]};
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] i);
    return (i == REG_CODE_C) || (i == REG_CODE_B) || (i == REG_CODE_A) ||
           (i == REG_MODE) || (i == REG_STAT);
  endfunction

  // ----------------------------------------------------------------------------
  // supply monitor and link crossing
  // ----------------------------------------------------------------------------
  logic vio_s1_r;
  logic vio_s_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vio_s1_r <= 1'b0;
      vio_s_r  <= 1'b0;
    end
    else
    begin
      vio_s1_r <= vio_ok;
      vio_s_r  <= vio_s1_r;
    end
  end

  logic              lk_pulse;
  logic [IDX_W-1:0]  lk_addr;
  logic [DATA_W-1:0] lk_data;

  hvoc_link_cdc u_link (
    .link_clk  (link_clk),
    .core_clk  (core_clk),
    .nrst      (nrst),
    .link_wr   (link_wr),
    .link_addr (link_addr),
    .link_data (link_data),
    .link_busy (link_busy),
    .lk_pulse  (lk_pulse),
    .lk_addr   (lk_addr),
    .lk_data   (lk_data)
  );

  // ----------------------------------------------------------------------------
  // write arbitration
  // ----------------------------------------------------------------------------
  // the link pulse cannot wait, so it wins; a bus write just waits a cycle
  logic              wr_go;
  logic [IDX_W:0]    aw_dec;
  logic              wr_en;
  logic [IDX_W-1:0]  wr_idx;
  logic [DATA_W-1:0] wr_data;

  assign aw_dec = addr_to_idx(s_axi_awaddr);
  assign wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                  !s_axi_bvalid && !lk_pulse;

  always_comb
  begin
    wr_en   = 1'b0;
    wr_idx  = '0;
    wr_data = '0;
    if (lk_pulse)
    begin
      wr_en   = 1'b1;
      wr_idx  = lk_addr;
      wr_data = lk_data;
    end
    else if (wr_go && s_axi_wstrb[0] && !aw_dec[0])
    begin
      wr_en   = 1'b1;
      wr_idx  = aw_dec[IDX_W:1];
      wr_data = s_axi_wdata[DATA_W-1:0];
    end
  end

  logic       pm_wr;
  logic [1:0] pm_val;
  logic       soft_rst;
  logic       pm_ignore;

  assign pm_wr     = wr_en && (wr_idx == REG_MODE);
  assign pm_val    = wr_data[PM_HI:PM_LO];
  assign soft_rst  = pm_wr && (pm_val == PM_STARTUP);
  assign pm_ignore = pm_wr && (pm_val == PM_UNDEF);

  // ----------------------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------------------
  hvoc_mode_t mode_r;
  hvoc_mode_t mode_nxt;

  always_comb
  begin
    mode_nxt = mode_r;
    unique case (mode_r)
      HVOC_SHUT:
        if (vio_s_r)
          mode_nxt = HVOC_ACT;
      HVOC_ACT:
        if (!vio_s_r)
          mode_nxt = HVOC_SHUT;
        else if (pm_wr && (pm_val == PM_LOWPWR))
          mode_nxt = HVOC_LOWP;
      HVOC_LOWP:
        if (!vio_s_r)
          mode_nxt = HVOC_SHUT;
        else if (soft_rst)
          mode_nxt = HVOC_ACT;
      default:
        mode_nxt = HVOC_SHUT;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      mode_r <= HVOC_SHUT;
    else
      mode_r <= mode_nxt;
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  // while the supply is low everything is held at defaults, so the supply
  // return behaves as a power-on reset
  logic       regs_clr;
  logic [1:0] pm_field_r;
  logic [5:0] ctrl_r;

  assign regs_clr = !vio_s_r || soft_rst;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_code
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          code_r[gi] <= CODE_ZERO;
        else if (regs_clr)
          code_r[gi] <= CODE_ZERO;
        else if (wr_en && (wr_idx == IDX_W'(gi)))
          code_r[gi] <= wr_data[CODE_W-1:0];
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pm_field_r <= PM_ACTIVE;
      ctrl_r     <= CTRL_RST;
    end
    else if (regs_clr)
    begin
      pm_field_r <= PM_ACTIVE;
      ctrl_r     <= CTRL_RST;
    end
    else if (pm_wr && !pm_ignore)
    begin
      pm_field_r <= pm_val;
      ctrl_r     <= wr_data[5:0];
    end
  end

  // ----------------------------------------------------------------------------
  // output control
  // ----------------------------------------------------------------------------
  // each channel decides alone, so one off channel leaves the others untouched
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_out
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          pd_r[gi]  <= 1'b1;
          lvl_r[gi] <= '0;
        end
        else if ((mode_r == HVOC_ACT) && (code_r[gi] != CODE_ZERO))
        begin
          pd_r[gi]  <= 1'b0;
          lvl_r[gi] <= code_to_mv(code_r[gi]);
        end
        else
        begin
          pd_r[gi]  <= 1'b1;
          lvl_r[gi] <= '0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      boost_en   <= 1'b0;
      mode_state <= HVOC_SHUT;
    end
    else
    begin
      boost_en   <= (mode_r == HVOC_ACT);
      mode_state <= mode_r;
    end
  end

  assign high_voltage_output_c_code     = code_r[0];
  assign high_voltage_output_b_code     = code_r[1];
  assign high_voltage_output_a_code     = code_r[2];
  assign high_voltage_output_c_mv       = lvl_r[0];
  assign high_voltage_output_b_mv       = lvl_r[1];
  assign high_voltage_output_a_mv       = lvl_r[2];
  assign high_voltage_output_c_pulldown = pd_r[0];
  assign high_voltage_output_b_pulldown = pd_r[1];
  assign high_voltage_output_a_pulldown = pd_r[2];

  // ----------------------------------------------------------------------------
  // bus write channel
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (!aw_dec[0] && is_mapped(aw_dec[IDX_W:1])) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // bus read channel
  // ----------------------------------------------------------------------------
  logic           rd_go;
  logic [IDX_W:0] ar_dec;
  logic [31:0]    rd_word;

  assign ar_dec = addr_to_idx(s_axi_araddr);
  assign rd_go  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  always_comb
  begin
    rd_word = '0;
    if (!ar_dec[0])
    begin
      unique case (ar_dec[IDX_W:1])
        REG_CODE_C: rd_word[CODE_W-1:0] = code_r[0];
        REG_CODE_B: rd_word[CODE_W-1:0] = code_r[1];
        REG_CODE_A: rd_word[CODE_W-1:0] = code_r[2];
        REG_MODE:   rd_word[DATA_W-1:0] = {pm_field_r, ctrl_r};
        REG_STAT:
        begin
          rd_word[STAT_MODE_LO+1:STAT_MODE_LO]       = mode_r;
          rd_word[STAT_PD_LO+NUM_OUT-1:STAT_PD_LO]   = pd_r;
          rd_word[STAT_VIO]                          = vio_s_r;
        end
        default:    rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (!ar_dec[0] && is_mapped(ar_dec[IDX_W:1])) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> shared/hvoc_pkg.sv
// package: constants and types of the hv output mode and code control core
// ----------------------------------------------------------------------------
// Function
// - hold three separate 7-bit codes, one per output, each picking one of 128 levels
// - code zero disconnects an output and pulls it to ground instead of driving it
// - level steps are 100 mV up to 3c, 200 mV to 48, 300 mV to 7f
// - with interface supply low, shutdown: all blocks off, all outputs pulled down
// - supply turn-on or power field 01 enters active mode, outputs follow codes
// - in active mode each output is controlled and switched off independently
// - power field 10 enters low power; only the serial interface keeps working
// - supply rising past its threshold resets every register and the mode
// - writing 01 to the power field resets all registers and enters active mode
// - codes for outputs c, b, a sit in registers 0, 1, 2
// - power field, top two bits of register 28: 00 active, 01 startup, 10 low power
// ----------------------------------------------------------------------------
package hvoc_pkg;
  localparam int CODE_W  = 7;
  localparam int NUM_OUT = 3;
  localparam int LVL_W   = 15;
  localparam int IDX_W   = 5;
  localparam int AXI_AW  = 8;
  localparam int DATA_W  = 8;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] REG_CODE_C = 5'h00;
  localparam logic [IDX_W-1:0] REG_CODE_B = 5'h01;
  localparam logic [IDX_W-1:0] REG_CODE_A = 5'h02;
  localparam logic [IDX_W-1:0] REG_STAT   = 5'h08;
  localparam logic [IDX_W-1:0] REG_MODE   = 5'h1c;

  localparam logic [5:0] CTRL_RST = 6'h38;
  localparam int PM_HI = 7;
  localparam int PM_LO = 6;
  localparam logic [1:0] PM_ACTIVE  = 2'h0;
  localparam logic [1:0] PM_STARTUP = 2'h1;
  localparam logic [1:0] PM_LOWPWR  = 2'h2;
  localparam logic [1:0] PM_UNDEF   = 2'h3;

  localparam logic [CODE_W-1:0] CODE_ZERO = 7'h00;
  localparam logic [CODE_W-1:0] CODE_BRK1 = 7'h3c;
  localparam logic [CODE_W-1:0] CODE_BRK2 = 7'h48;
  localparam logic [LVL_W-1:0]  STEP1_MV  = 15'h0064;
  localparam logic [LVL_W-1:0]  STEP2_MV  = 15'h00c8;
  localparam logic [LVL_W-1:0]  STEP3_MV  = 15'h012c;
  localparam logic [LVL_W-1:0]  LVL_BRK1  = 15'h1770;
  localparam logic [LVL_W-1:0]  LVL_BRK2  = 15'h20d0;

  localparam int STAT_MODE_LO = 0;
  localparam int STAT_PD_LO   = 2;
  localparam int STAT_VIO     = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    HVOC_SHUT = 2'h0,
    HVOC_ACT  = 2'h1,
    HVOC_LOWP = 2'h3
  } hvoc_mode_t;
endpackage

// >>> hw/hvoc_link_cdc.sv
// module: link-side write capture and toggle handshake into the core clock
`timescale 1ns/1ns
module hvoc_link_cdc
  import hvoc_pkg::*;
(
  input  wire logic              link_clk,
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              link_wr,
  input  wire logic [IDX_W-1:0]  link_addr,
  input  wire logic [DATA_W-1:0] link_data,
  output logic                   link_busy,
  output logic                   lk_pulse,
  output logic [IDX_W-1:0]       lk_addr,
  output logic [DATA_W-1:0]      lk_data
);
  logic req_t_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;

  // ----------------------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------------------
  // held words stay still until the ack returns, so the core may read them freely
  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_t_r   <= 1'b0;
      link_busy <= 1'b0;
      lk_addr   <= '0;
      lk_data   <= '0;
    end
    else if (link_wr && !link_busy)
    begin
      req_t_r   <= ~req_t_r;
      link_busy <= 1'b1;
      lk_addr   <= link_addr;
      lk_data   <= link_data;
    end
    else if (link_busy && (ack_s2_r == req_t_r))
      link_busy <= 1'b0;
  end

  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end
    else
    begin
      // ack from the pulse stage, so the held word outlives the core write
      ack_s1_r <= req_s3_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  // ----------------------------------------------------------------------------
  // core domain
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      lk_pulse <= 1'b0;
    end
    else
    begin
      req_s1_r <= req_t_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      lk_pulse <= req_s2_r ^ req_s3_r;
    end
  end
endmodule

// >>> sim/hvoc_top_properties.sv
// checker: port-level properties of the hv output mode and code control core
`timescale 1ns/1ns
module hvoc_top_props
  import hvoc_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              link_clk,
  input wire logic              vio_ok,
  input wire logic              link_wr,
  input wire logic              link_busy,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_bvalid,
  input wire logic [CODE_W-1:0] high_voltage_output_a_code,
  input wire logic [LVL_W-1:0]  high_voltage_output_a_mv,
  input wire logic              high_voltage_output_a_pulldown,
  input wire logic              high_voltage_output_b_pulldown,
  input wire logic              high_voltage_output_c_pulldown,
  input wire logic              boost_en,
  input wire logic [1:0]        mode_state
);
  wire [2:0] pd = {high_voltage_output_a_pulldown, high_voltage_output_b_pulldown, high_voltage_output_c_pulldown};
  wire [1:0] pf = s_axi_wdata[PM_HI:PM_LO];
  // a mode write on the cycle it is offered, before the slave answers
  wire       pw = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid && s_axi_wstrb[0] &&
                  s_axi_awaddr == {1'b0, REG_MODE, 2'b00};

  function automatic logic [LVL_W-1:0] lvl(input logic [CODE_W-1:0] c);
    if (c <= CODE_BRK1)
      return c * STEP1_MV;
    if (c <= CODE_BRK2)
      return LVL_BRK1 + (c - CODE_BRK1) * STEP2_MV;
    return LVL_BRK2 + (c - CODE_BRK2) * STEP3_MV;
  endfunction

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  AST_SHUT_VIO: assert property (@(posedge core_clk) disable iff (!nrst)
    !vio_ok [*5] |-> mode_state == HVOC_SHUT) else $error("not shut down with supply low");
  AST_PD_IDLE: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_state != HVOC_ACT && $past(mode_state) != HVOC_ACT |-> pd == 3'h7) else $error("pull-down released");
  AST_PD_CODE: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_state == HVOC_ACT && $past(mode_state) == HVOC_ACT && $stable(high_voltage_output_a_code)
    |-> high_voltage_output_a_pulldown == (high_voltage_output_a_code == CODE_ZERO)) else $error("pull-down vs code");
  AST_MV_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    high_voltage_output_a_pulldown |-> high_voltage_output_a_mv == '0) else $error("level while pulled down");
  AST_MV_LVL: assert property (@(posedge core_clk) disable iff (!nrst)
    !high_voltage_output_a_pulldown && $stable(high_voltage_output_a_code)
    |-> high_voltage_output_a_mv == lvl(high_voltage_output_a_code)) else $error("level mapping");
  AST_BOOST: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(mode_state) == mode_state |-> boost_en == (mode_state == HVOC_ACT)) else $error("boost vs mode");
  AST_LOWP: assert property (@(posedge core_clk) disable iff (!nrst)
    pw && pf == PM_LOWPWR && mode_state == HVOC_ACT |-> ##[1:8] mode_state == HVOC_LOWP) else $error("no low power");
  AST_UNDEF: assert property (@(posedge core_clk) disable iff (!nrst)
    pw && pf == PM_UNDEF && mode_state == HVOC_ACT |=> (mode_state == HVOC_ACT) [*4]) else $error("mode moved");
  AST_SOFT: assert property (@(posedge core_clk) disable iff (!nrst)
    pw && pf == PM_STARTUP && mode_state != HVOC_SHUT
    |-> ##[1:8] mode_state == HVOC_ACT && high_voltage_output_a_code == CODE_ZERO) else $error("no soft reset");
  AST_LINK: assert property (@(posedge link_clk) disable iff (!nrst)
    link_wr && !link_busy |=> link_busy) else $error("link write not taken");

  cover property (@(posedge core_clk) disable iff (!nrst) pw);
  cover property (@(posedge core_clk) disable iff (!nrst) mode_state == HVOC_LOWP);
  cover property (@(posedge link_clk) disable iff (!nrst) link_wr && !link_busy);
endmodule

bind hvoc_top hvoc_top_props u_props (.*);

// >>> sim/hvoc_link_master.sv
// partner: link-side master writing one register index and byte per frame
`timescale 1ns/1ns
module hvoc_link_master
  import hvoc_pkg::*;
(
  output logic              link_clk,
  output logic              link_wr,
  output logic [IDX_W-1:0]  link_addr,
  output logic [DATA_W-1:0] link_data,
  input  wire logic         link_busy
);
  initial
  begin
    link_clk  = 1'b0;
    link_wr   = 1'b0;
    link_addr = '0;
    link_data = '0;
  end

  // the clock is parked low outside frames, as a real master leaves it
  task automatic pulse(input int n);
    repeat (n)
    begin
      #3 link_clk = 1'b1;
      #3 link_clk = 1'b0;
    end
  endtask

  task automatic send(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] dat, output bit ok);
    int n;
    link_wr   = 1'b1;
    link_addr = idx;
    link_data = dat;
    #3 link_clk = 1'b1;
    link_wr   <= 1'b0;
    link_addr <= ~idx;
    link_data <= ~dat;
    #3 link_clk = 1'b0;
    // keep clocking until the core has acknowledged, or the handshake stalls
    for (n = 0; n < 40 && link_busy; n++)
      pulse(1);
    ok = (n < 40);
  endtask
endmodule

// >>> sim/tb_hvoc_top.sv
// testbench: hv output core driven over axi-lite and the link, with a queued scoreboard
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_hvoc_top
  import hvoc_pkg::*;
();
  logic              core_clk, nrst, vio_ok, sn, ok;
  logic              link_clk, link_wr, link_busy, boost_en;
  logic [IDX_W-1:0]  link_addr;
  logic [DATA_W-1:0] link_data;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]        s_axi_awprot, s_axi_arprot;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, mode_state;
  logic [CODE_W-1:0] high_voltage_output_a_code, high_voltage_output_b_code, high_voltage_output_c_code, rc;
  logic [LVL_W-1:0]  high_voltage_output_a_mv, high_voltage_output_b_mv, high_voltage_output_c_mv;
  logic              high_voltage_output_a_pulldown, high_voltage_output_b_pulldown, high_voltage_output_c_pulldown;
  logic [CODE_W-1:0] ec [3];
  logic [CODE_W-1:0] tab [8] = '{7'h01, 7'h3c, 7'h3d, 7'h48, 7'h49, 7'h7f, 7'h00, 7'h2a};
  hvoc_mode_t        em;
  logic [71:0]       oq [$];
  logic [33:0]       rq [$];
  logic [71:0]       eo;
  logic [33:0]       er;
  int                errors, comparisons;
  wire  [71:0]       obs = {boost_en, mode_state, high_voltage_output_a_pulldown, high_voltage_output_b_pulldown,
                            high_voltage_output_c_pulldown, high_voltage_output_a_mv, high_voltage_output_b_mv,
                            high_voltage_output_c_mv, high_voltage_output_a_code, high_voltage_output_b_code,
                            high_voltage_output_c_code};

  hvoc_top DUT (.*);
  hvoc_link_master lm (.*);

  always #5 core_clk = ~core_clk;

  function automatic logic [LVL_W-1:0] lvl(input logic [CODE_W-1:0] c);
    if (c <= CODE_BRK1)
      return c * STEP1_MV;
    if (c <= CODE_BRK2)
      return LVL_BRK1 + (c - CODE_BRK1) * STEP2_MV;
    return LVL_BRK2 + (c - CODE_BRK2) * STEP3_MV;
  endfunction

  function automatic logic [71:0] eobs();
    logic [2:0]  pd;
    logic [44:0] mv;
    for (int i = 0; i < 3; i++)
    begin
      pd[i] = em != HVOC_ACT || ec[i] == CODE_ZERO;
      mv[15*i +: 15] = pd[i] ? '0 : lvl(ec[i]);
    end
    return {em == HVOC_ACT, em, pd, mv, ec[2], ec[1], ec[0]};
  endfunction

  // ---------------------------------------------------------------------------
  // monitor: each result takes the oldest note of its kind
  // ---------------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (sn)
    begin
      eo = oq.pop_front();
      `CHK(obs, eo)
    end
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
    begin
      er = rq.pop_front();
      `CHK(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, er)
    end
  end

  // ---------------------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic stall_out();
    errors++;
    finish_test();
  endtask

  // readys and valids are sampled at the edge, before that edge's updates land
  task automatic hs(input bit is_rd);
    int n;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (is_rd ? s_axi_rvalid : s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n == 50)
      stall_out();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge core_clk);
    rq.push_back({r, 32'h0});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'($urandom()), d};
    s_axi_wstrb   <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    hs(1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge core_clk);
    rq.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    hs(1'b1);
  endtask

  task automatic look(input int w);
    repeat (w) @(posedge core_clk);
    oq.push_back(eobs());
    sn <= 1'b1;
    @(posedge core_clk);
    sn <= 1'b0;
  endtask

  task automatic code(input int i, input logic [CODE_W-1:0] c);
    wr(8'(4 * i), {1'b0, c}, RESP_OKAY);
    if (em != HVOC_SHUT)
      ec[i] = c;
    look(3);
    rd(8'(4 * i), {RESP_OKAY, 25'h0, ec[i]});
  endtask

  initial
  begin
    core_clk = 1'b0; nrst = 1'b0; vio_ok = 1'b0; sn = 1'b0;
    s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_awprot = '0; s_axi_arprot = '0; s_axi_wdata = '0;
    s_axi_wstrb = '0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    errors = 0; comparisons = 0;
    em = HVOC_SHUT;
    ec = '{default: '0};
    void'($urandom(56));
    lm.pulse(2);
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    code(2, 7'h55);
    vio_ok <= 1'b1;
    em = HVOC_ACT;
    look(6);
    for (int k = 0; k < 11; k++)
      code(k % 3, k < 8 ? tab[k] : 7'($urandom_range(127, 1)));
    rd(8'h0c, {RESP_SLVERR, 32'h0});
    wr(8'h0d, 8'h11, RESP_SLVERR);
    rd(8'h70, {RESP_OKAY, 24'h0, PM_ACTIVE, CTRL_RST});
    rc = 7'($urandom_range(127, 1));
    lm.send(REG_CODE_A, {1'b0, rc}, ok);
    if (!ok)
      stall_out();
    ec[2] = rc;
    look(4);
    wr(8'h70, {PM_UNDEF, 6'h05}, RESP_OKAY);
    look(3);
    rd(8'h70, {RESP_OKAY, 24'h0, PM_ACTIVE, CTRL_RST});
    wr(8'h70, {PM_LOWPWR, CTRL_RST}, RESP_OKAY);
    em = HVOC_LOWP;
    look(3);
    rd(8'h70, {RESP_OKAY, 24'h0, PM_LOWPWR, CTRL_RST});
    code(1, 7'h22);
    wr(8'h70, {PM_STARTUP, 6'h00}, RESP_OKAY);
    em = HVOC_ACT;
    ec = '{default: '0};
    look(3);
    rd(8'h70, {RESP_OKAY, 24'h0, PM_ACTIVE, CTRL_RST});
    code(0, 7'h7f);
    vio_ok <= 1'b0;
    em = HVOC_SHUT;
    ec = '{default: '0};
    look(6);
    vio_ok <= 1'b1;
    em = HVOC_ACT;
    look(6);
    rd(8'h00, {RESP_OKAY, 32'h0});
    finish_test();
  end
endmodule
